// >>> rtl/epd_pkg.sv
// Shared constants and types for the e-paper command sequencer
package epd_pkg;
	// --------------------------------------------------------------
	// Command codes
	// --------------------------------------------------------------
	localparam logic [7:0] CMD_ENTRY     = 8'h11;
	localparam logic [7:0] CMD_SW_RESET  = 8'h12;
	localparam logic [7:0] CMD_ACTIVATE  = 8'h20;
	localparam logic [7:0] CMD_UPD_CTRL2 = 8'h22;
	localparam logic [7:0] CMD_WR_BW     = 8'h24;
	localparam logic [7:0] CMD_WR_RED    = 8'h26;
	localparam logic [7:0] CMD_RD_RAM    = 8'h27;
	localparam logic [7:0] CMD_BORDER    = 8'h3c;
	localparam logic [7:0] CMD_RD_OPT    = 8'h41;
	localparam logic [7:0] CMD_WIN_X     = 8'h44;
	localparam logic [7:0] CMD_WIN_Y     = 8'h45;
	localparam logic [7:0] CMD_CNT_X     = 8'h4e;
	localparam logic [7:0] CMD_CNT_Y     = 8'h4f;
	localparam logic [7:0] CMD_ANALOG    = 8'h74;
	localparam logic [7:0] CMD_DIGITAL   = 8'h7e;
	// --------------------------------------------------------------
	// Border source codes and reset values
	// --------------------------------------------------------------
	localparam logic [1:0] BSRC_TABLE = 2'h0;
	localparam logic [1:0] BSRC_FIXED = 2'h1;
	localparam logic [1:0] BSRC_VCOM  = 2'h2;
	localparam logic [1:0] BSRC_HIZ   = 2'h3;
	localparam logic [1:0] BLVL_GND   = 2'h0;
	localparam logic [1:0] BTBL_ZERO  = 2'h0;
	localparam logic [4:0] XS_RST     = 5'h00;
	// Column end keeps only the five bits that the window field has, so the wide default wraps
	localparam logic [4:0] XE_RST     = 5'(8'h31);
	localparam logic [8:0] YS_RST     = 9'h12b;
	localparam logic [8:0] YE_RST     = 9'h000;
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] SEQ_RST    = 8'hff;
	localparam logic [7:0] DUMMY_BYTE = 8'h00;
	// --------------------------------------------------------------
	// Frame buffer geometry and sequence timing
	// --------------------------------------------------------------
	localparam int unsigned ROW_BYTES   = 50;
	localparam int unsigned ROWS        = 300;
	localparam int unsigned ADDR_W      = 14;
	localparam int unsigned TIMER_W     = 17;
	localparam int unsigned CLK_MHZ     = 50;
	localparam int unsigned RST_BUSY_NS = 20000;
	localparam int unsigned POWER_NS    = 40000;
	localparam int unsigned LUT_NS      = 60000;
	localparam int unsigned DRIVE_NS    = 2000000;
	localparam int unsigned OFF_NS      = 40000;
	localparam int unsigned RST_BUSY_CYC = (RST_BUSY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned POWER_CYC    = (POWER_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned LUT_CYC      = (LUT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned DRIVE_CYC    = (DRIVE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned OFF_CYC      = (OFF_NS * CLK_MHZ + 999) / 1000;
	// --------------------------------------------------------------
	// Types
	// --------------------------------------------------------------
	typedef struct packed {
		logic [1:0] src;
		logic [1:0] level;
		logic [1:0] tbl;
	} border_cfg_t;
	typedef struct packed {
		logic [4:0] xs;
		logic [4:0] xe;
		logic [8:0] ys;
		logic [8:0] ye;
	} window_t;
	typedef struct packed {
		logic       dc;
		logic [7:0] data;
	} rx_word_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RESET = 3'b001,
		ST_POWER = 3'b010,
		ST_LUT   = 3'b011,
		ST_DRIVE = 3'b100,
		ST_OFF   = 3'b101
	} seq_state_t;
endpackage : epd_pkg

// >>> rtl/serial_link.sv
// Link-side byte receiver and read-back shifter on the serial clock
module serial_link (
	// Resets
	input  wire logic        arst_n,
	// Serial pins
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        sda_i,
	input  wire logic        dc_i,
	output logic             sda_o,
	output logic             sda_oe,
	// Towards the core domain
	input  wire logic [7:0]  rd_byte,
	input  wire logic        rd_mode,
	output epd_pkg::rx_word_t rx_word,
	output logic             rx_tgl
);
	logic [2:0] bit_q;
	logic [6:0] sh_q;
	logic       mode_s1_q;
	logic       mode_s2_q;

	// Bit count ends with the frame: chip select high clears it with no clock
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_q <= 3'h0;
			sh_q  <= 7'h00;
		end else begin
			bit_q <= bit_q + 3'h1;
			sh_q  <= {sh_q[5:0], sda_i};
		end
	end

	// Word is written together with the toggle; the core reads it two edges later, when it is settled
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_word <= '0;
			rx_tgl  <= 1'b0;
		end else if (bit_q == 3'h7) begin
			rx_word <= '{dc: dc_i, data: {sh_q, sda_i}};
			rx_tgl  <= ~rx_tgl;
		end
	end

	// Read data changes on falling edges; read mode is a level so two flops carry it across
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			mode_s1_q <= 1'b0;
			mode_s2_q <= 1'b0;
			sda_o     <= 1'b0;
			sda_oe    <= 1'b0;
		end else begin
			mode_s1_q <= rd_mode;
			mode_s2_q <= mode_s1_q;
			sda_oe    <= mode_s2_q;
			sda_o     <= rd_byte[3'h7 - bit_q];
		end
	end

	byte_toggle_a: assert property (@(negedge sclk) disable iff (cs_n || !arst_n)
		bit_q == 3'h0 |-> rx_tgl != $past(rx_tgl)) else $error("completed byte did not toggle");
endmodule : serial_link

// >>> rtl/frame_ram.sv
// Two-plane frame buffer with one write port and one registered read port
module frame_ram #(
	parameter int unsigned DEPTH  = epd_pkg::ROW_BYTES * epd_pkg::ROWS,
	parameter int unsigned ADDR_W = epd_pkg::ADDR_W
) (
	// Clock
	input  wire logic              clk,
	// Write port
	input  wire logic              we,
	input  wire logic              wplane,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	// Read port, same address
	input  wire logic              rplane,
	output logic [7:0]             q
);
	logic [7:0] bw_mem  [DEPTH];
	logic [7:0] red_mem [DEPTH];

	// Plane 0 holds black/white, plane 1 holds red; no reset, contents are undefined at power-up
	always_ff @(posedge clk) begin
		if (we && !wplane) begin
			bw_mem[addr] <= wdata;
		end
		if (we && wplane) begin
			red_mem[addr] <= wdata;
		end
		q <= rplane ? red_mem[addr] : bw_mem[addr];
	end
endmodule : frame_ram

// >>> rtl/epaper_command_sequencer.sv
// Command interpreter of the e-paper driver: serial link, settings, frame buffer and update sequence
module epaper_command_sequencer #(
	parameter int unsigned DRIVE_CYCLES = epd_pkg::DRIVE_CYC
) (
	// Core clock and reset
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire logic                  hardware_reset_n,
	// Serial link
	input  wire logic                  sclk,
	input  wire logic                  cs_n,
	input  wire logic                  sda_i,
	input  wire logic                  dc_i,
	output logic                       sda_o,
	output logic                       sda_oe,
	// Factory memory value
	input  wire logic [7:0]            otp_vcom,
	// Settings
	output epd_pkg::border_cfg_t       border_cfg,
	output logic                       read_red,
	output epd_pkg::window_t           window,
	output logic [4:0]                 ram_x,
	output logic [8:0]                 ram_y,
	output logic [7:0]                 analog_ctrl,
	output logic [7:0]                 digital_ctrl,
	output logic [7:0]                 update_seq,
	output logic [7:0]                 vcom,
	// Sequence status
	output logic                       busy,
	output logic                       booster_en,
	output logic                       lut_load,
	output logic                       drive_en
);
	// --------------------------------------------------------------
	// Link domain and crossing
	// --------------------------------------------------------------
	epd_pkg::rx_word_t rx_word;
	logic              rx_tgl;
	logic              tgl_s1_q;
	logic              tgl_s2_q;
	logic              tgl_s3_q;
	logic              hr_s1_q;
	logic              hr_s2_q;
	logic [7:0]        rd_byte_q;
	logic              rd_mode_q;

	serial_link u_link (
		.arst_n  (arst_n),
		.sclk    (sclk),
		.cs_n    (cs_n),
		.sda_i   (sda_i),
		.dc_i    (dc_i),
		.sda_o   (sda_o),
		.sda_oe  (sda_oe),
		.rd_byte (rd_byte_q),
		.rd_mode (rd_mode_q),
		.rx_word (rx_word),
		.rx_tgl  (rx_tgl)
	);

	// Byte event crosses as a toggle; the reset pin is a level and takes two flops too
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
			hr_s1_q  <= 1'b0;
			hr_s2_q  <= 1'b0;
		end else begin
			tgl_s1_q <= rx_tgl;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
			hr_s1_q  <= hardware_reset_n;
			hr_s2_q  <= hr_s1_q;
		end
	end

	// --------------------------------------------------------------
	// Byte decode
	// --------------------------------------------------------------
	logic [7:0]  cmd_q;
	logic [1:0]  pidx_q;
	wire         evt      = tgl_s2_q ^ tgl_s3_q;
	wire         hw_rst   = !hr_s2_q;
	wire [7:0]   rx_data  = rx_word.data;
	wire         is_cmd   = evt && !rx_word.dc;
	wire         is_par   = evt && rx_word.dc && !rd_mode_q;
	wire         is_rdb   = evt && rx_word.dc && rd_mode_q;
	wire         sw_rst   = is_cmd && rx_data == epd_pkg::CMD_SW_RESET;
	wire         p_border = is_par && cmd_q == epd_pkg::CMD_BORDER;
	wire         p_rdopt  = is_par && cmd_q == epd_pkg::CMD_RD_OPT;
	wire         p_winx   = is_par && cmd_q == epd_pkg::CMD_WIN_X;
	wire         p_winy   = is_par && cmd_q == epd_pkg::CMD_WIN_Y;
	wire         p_cntx   = is_par && cmd_q == epd_pkg::CMD_CNT_X;
	wire         p_cnty   = is_par && cmd_q == epd_pkg::CMD_CNT_Y;
	wire         p_wr_bw  = is_par && cmd_q == epd_pkg::CMD_WR_BW;
	wire         p_wr_red = is_par && cmd_q == epd_pkg::CMD_WR_RED;

	// Parameter index saturates so surplus bytes of a short command are ignored
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_q  <= 8'h00;
			pidx_q <= 2'h0;
		end else if (is_cmd) begin
			cmd_q  <= rx_data;
			pidx_q <= 2'h0;
		end else if (is_par && pidx_q != 2'h3) begin
			pidx_q <= pidx_q + 2'h1;
		end
	end

	// --------------------------------------------------------------
	// Address counter and frame buffer
	// --------------------------------------------------------------
	logic [7:0]  ram_q;
	wire         ram_we   = p_wr_bw || p_wr_red;
	wire         step     = ram_we || is_rdb;
	wire         x_wrap   = ram_x == window.xe;
	wire         y_wrap   = ram_y == window.ye;
	wire [4:0]   x_next   = x_wrap ? window.xs : ram_x + 5'h01;
	wire [8:0]   y_next   = !x_wrap ? ram_y : (y_wrap ? window.ys : ram_y - 9'h001);
	localparam int unsigned ADDR_W_L = epd_pkg::ADDR_W;
	wire [ADDR_W_L-1:0] row_base = ADDR_W_L'(ram_y) * ADDR_W_L'(epd_pkg::ROW_BYTES);
	wire [ADDR_W_L-1:0] ram_addr = row_base + ADDR_W_L'(ram_x);

	frame_ram u_ram (
		.clk    (clk),
		.we     (ram_we),
		.wplane (p_wr_red),
		.addr   (ram_addr),
		.wdata  (rx_data),
		.rplane (read_red),
		.q      (ram_q)
	);

	// --------------------------------------------------------------
	// Settings registers
	// --------------------------------------------------------------
	wire         defaults = hw_rst || sw_rst;

	// Reset and software reset load defaults; a parameter byte lands in its field by index
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			border_cfg   <= '{src: epd_pkg::BSRC_TABLE, level: epd_pkg::BLVL_GND, tbl: epd_pkg::BTBL_ZERO};
			read_red     <= 1'b0;
			window       <= '{xs: epd_pkg::XS_RST, xe: epd_pkg::XE_RST, ys: epd_pkg::YS_RST, ye: epd_pkg::YE_RST};
			analog_ctrl  <= epd_pkg::CTRL_RST;
			digital_ctrl <= epd_pkg::CTRL_RST;
			update_seq   <= epd_pkg::SEQ_RST;
		end else if (defaults) begin
			border_cfg   <= '{src: epd_pkg::BSRC_TABLE, level: epd_pkg::BLVL_GND, tbl: epd_pkg::BTBL_ZERO};
			read_red     <= 1'b0;
			window       <= '{xs: epd_pkg::XS_RST, xe: epd_pkg::XE_RST, ys: epd_pkg::YS_RST, ye: epd_pkg::YE_RST};
			analog_ctrl  <= epd_pkg::CTRL_RST;
			digital_ctrl <= epd_pkg::CTRL_RST;
			update_seq   <= epd_pkg::SEQ_RST;
		end else if (is_par && pidx_q == 2'h0) begin
			if (p_border) begin
				border_cfg <= '{src: rx_data[7:6], level: rx_data[5:4], tbl: rx_data[1:0]};
			end
			if (p_rdopt) begin
				read_red <= rx_data[0];
			end
			if (p_winx) begin
				window.xs <= rx_data[4:0];
			end
			if (p_winy) begin
				window.ys[7:0] <= rx_data;
			end
			if (cmd_q == epd_pkg::CMD_ANALOG) begin
				analog_ctrl <= rx_data;
			end
			if (cmd_q == epd_pkg::CMD_DIGITAL) begin
				digital_ctrl <= rx_data;
			end
			if (cmd_q == epd_pkg::CMD_UPD_CTRL2) begin
				update_seq <= rx_data;
			end
		end else if (is_par && pidx_q == 2'h1) begin
			if (p_winx) begin
				window.xe <= rx_data[4:0];
			end
			if (p_winy) begin
				window.ys[8] <= rx_data[0];
			end
		end else if (p_winy && pidx_q == 2'h2) begin
			window.ye[7:0] <= rx_data;
		end else if (p_winy && pidx_q == 2'h3) begin
			window.ye[8] <= rx_data[0];
		end
	end

	// Counter is loaded by its commands and steps on every stored or fetched data byte
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ram_x <= epd_pkg::XS_RST;
			ram_y <= epd_pkg::YS_RST;
		end else if (defaults) begin
			ram_x <= epd_pkg::XS_RST;
			ram_y <= epd_pkg::YS_RST;
		end else if (p_cntx && pidx_q == 2'h0) begin
			ram_x <= rx_data[4:0];
		end else if (p_cnty && pidx_q == 2'h0) begin
			ram_y[7:0] <= rx_data;
		end else if (p_cnty && pidx_q == 2'h1) begin
			ram_y[8] <= rx_data[0];
		end else if (step) begin
			ram_x <= x_next;
			ram_y <= y_next;
		end
	end

	// Read-back: the read command queues a dummy; each clocked-out byte then fetches the next
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_mode_q <= 1'b0;
			rd_byte_q <= epd_pkg::DUMMY_BYTE;
		end else if (is_cmd) begin
			rd_mode_q <= rx_data == epd_pkg::CMD_RD_RAM;
			rd_byte_q <= epd_pkg::DUMMY_BYTE;
		end else if (is_rdb) begin
			rd_byte_q <= ram_q;
		end
	end

	// --------------------------------------------------------------
	// Reset and update sequence
	// --------------------------------------------------------------
	localparam int unsigned TIMER_W_L = epd_pkg::TIMER_W;
	epd_pkg::seq_state_t state_q;
	epd_pkg::seq_state_t state_d;
	logic [TIMER_W_L-1:0] timer_q;
	logic [TIMER_W_L-1:0] timer_d;
	wire         act      = is_cmd && rx_data == epd_pkg::CMD_ACTIVATE;
	wire         t_done   = timer_q == TIMER_W_L'(1);

	// Next state; an activation during a running sequence is ignored so the panel is not corrupted
	always_comb begin
		state_d = state_q;
		timer_d = timer_q - TIMER_W_L'(1);
		unique case (state_q)
			epd_pkg::ST_IDLE: begin
				timer_d = timer_q;
				if (act) begin
					state_d = epd_pkg::ST_POWER;
					timer_d = TIMER_W_L'(epd_pkg::POWER_CYC);
				end
			end
			epd_pkg::ST_RESET: if (t_done) state_d = epd_pkg::ST_IDLE;
			epd_pkg::ST_POWER: begin
				if (t_done) begin
					state_d = epd_pkg::ST_LUT;
					timer_d = TIMER_W_L'(epd_pkg::LUT_CYC);
				end
			end
			epd_pkg::ST_LUT: begin
				if (t_done) begin
					state_d = epd_pkg::ST_DRIVE;
					timer_d = TIMER_W_L'(DRIVE_CYCLES);
				end
			end
			epd_pkg::ST_DRIVE: begin
				if (t_done) begin
					state_d = epd_pkg::ST_OFF;
					timer_d = TIMER_W_L'(epd_pkg::OFF_CYC);
				end
			end
			epd_pkg::ST_OFF: if (t_done) state_d = epd_pkg::ST_IDLE;
			default: state_d = epd_pkg::ST_IDLE;
		endcase
		if (sw_rst) begin
			state_d = epd_pkg::ST_RESET;
			timer_d = TIMER_W_L'(epd_pkg::RST_BUSY_CYC);
		end
		if (hw_rst) begin
			state_d = epd_pkg::ST_IDLE;
			timer_d = '0;
		end
	end

	// State, timer and the registered sequence outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q    <= epd_pkg::ST_IDLE;
			timer_q    <= '0;
			busy       <= 1'b0;
			booster_en <= 1'b0;
			lut_load   <= 1'b0;
			drive_en   <= 1'b0;
		end else begin
			state_q    <= state_d;
			timer_q    <= timer_d;
			busy       <= state_d != epd_pkg::ST_IDLE;
			booster_en <= state_d inside {epd_pkg::ST_POWER, epd_pkg::ST_LUT, epd_pkg::ST_DRIVE};
			lut_load   <= state_d == epd_pkg::ST_LUT;
			drive_en   <= state_d == epd_pkg::ST_DRIVE;
		end
	end

	// Factory common-voltage value is reloaded by software reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vcom <= epd_pkg::CTRL_RST;
		end else if (sw_rst) begin
			vcom <= otp_vcom;
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	sw_reset_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
		sw_rst && !hw_rst |=> busy && vcom == $past(otp_vcom) && border_cfg.src == epd_pkg::BSRC_TABLE)
		else $error("software reset did not reload and raise busy");
	border_fields_a: assert property (@(posedge clk) disable iff (!arst_n)
		p_border && pidx_q == 2'h0 && !defaults |=> border_cfg.src == $past(rx_data[7:6])
		&& border_cfg.level == $past(rx_data[5:4]) && border_cfg.tbl == $past(rx_data[1:0]))
		else $error("border fields not taken");
	read_select_a: assert property (@(posedge clk) disable iff (!arst_n)
		p_rdopt && pidx_q == 2'h0 && !defaults |=> read_red == $past(rx_data[0]))
		else $error("read buffer select not taken");
	window_end_a: assert property (@(posedge clk) disable iff (!arst_n)
		p_winx && pidx_q == 2'h1 && !defaults |=> window.xe == $past(rx_data[4:0]))
		else $error("column window end not taken");
	row_high_a: assert property (@(posedge clk) disable iff (!arst_n)
		p_cnty && pidx_q == 2'h1 && !defaults |=> ram_y[8] == $past(rx_data[0]) && ram_y[7:0] == $past(ram_y[7:0]))
		else $error("row counter bit 8 not taken");
	write_step_a: assert property (@(posedge clk) disable iff (!arst_n)
		p_wr_bw && !defaults |-> ram_we && !p_wr_red ##1 ram_x == $past(x_next) && ram_y == $past(y_next))
		else $error("written byte did not advance the counter");
	dummy_first_a: assert property (@(posedge clk) disable iff (!arst_n)
		is_cmd && rx_data == epd_pkg::CMD_RD_RAM |=> rd_mode_q && rd_byte_q == epd_pkg::DUMMY_BYTE)
		else $error("read did not queue a dummy byte");
	update_power_a: assert property (@(posedge clk) disable iff (!arst_n || hw_rst)
		act && !sw_rst && state_q == epd_pkg::ST_IDLE |=> busy && booster_en && !lut_load ##1 busy[*3])
		else $error("activation did not start the booster");
	drive_booster_a: assert property (@(posedge clk) disable iff (!arst_n)
		(lut_load || drive_en) |-> booster_en && busy)
		else $error("table load or drive without power");
endmodule : epaper_command_sequencer

// >>> verif/host_link.sv
// Host-side model that drives the serial command link
module host_link (
	// Serial pins towards the device
	output logic      sclk,
	output logic      cs_n,
	output logic      sda_i,
	output logic      dc_i,
	// Read-back pins, watched only
	input  wire logic sda_o,
	input  wire logic sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       tick;
	logic [7:0] rd_q;
	// Ticks per clock phase: 3 for writes, 17 keeps read frames under their slower limit
	int         half = 3;
	// 12 ns timebase, phase-offset from the core clock; the serial clock only moves within frames
	initial begin
		tick = 1'b0;
		sclk = 1'b0;
		cs_n = 1'b1;
		sda_i = 1'b0;
		dc_i = 1'b0;
		#3;
		forever #6 tick = ~tick;
	end
	// One byte per frame; read-back bits are shifted in at rising edges while the device drives
	task send(input logic dc, input logic [7:0] b);
		@(posedge tick);
		cs_n = 1'b0;
		rd_q = 8'h00;
		dc_i = dc;
		repeat (2) @(posedge tick);
		for (int i = 7; i >= 0; i--) begin
			sda_i = b[i];
			repeat (half - 1) @(posedge tick);
			sclk = 1'b1;
			if (sda_oe === 1'b1) rd_q = {rd_q[6:0], sda_o};
			repeat (half) @(posedge tick);
			sclk = 1'b0;
			@(posedge tick);
		end
		repeat (2) @(posedge tick);
		cs_n = 1'b1;
		// Released line shows the inverse so a stale value is never mistaken for data
		sda_i = ~b[0];
		dc_i = ~dc;
		repeat (10) @(posedge tick);
	endtask : send
endmodule : host_link

// >>> verif/epaper_command_sequencer_tb.sv
// Self-checking bench for the e-paper command sequencer
module epaper_command_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int sel; logic [27:0] val;} note_t;
	logic                 clk, arst_n, hardware_reset_n, sclk, cs_n, sda_i, dc_i, sda_o, sda_oe;
	logic [7:0]           otp_vcom, analog_ctrl, digital_ctrl, update_seq, vcom;
	epd_pkg::border_cfg_t border_cfg;
	epd_pkg::window_t     window;
	logic                 read_red, busy, booster_en, lut_load, drive_en, saw_lut, saw_drive;
	logic [4:0]           ram_x, xs, xe, rx;
	logic [8:0]           ram_y, ys, ye, ry;
	logic [1:0]           lv, tb;
	int                   err_total, samples_checked, cyc;
	note_t                notes[$];
	note_t                w_note;
	event                 got;
	string names [0:12] = '{"border", "read_red", "window", "ram_x", "ram_y", "analog", "digital",
		"vcom", "busy", "phases", "update_seq", "booster", "read_back"};
	// ------------------------------------------------------------
	// Device and host model
	// ------------------------------------------------------------
	epaper_command_sequencer #(.DRIVE_CYCLES(50)) dut (.clk(clk), .arst_n(arst_n),
		.hardware_reset_n(hardware_reset_n), .sclk(sclk), .cs_n(cs_n), .sda_i(sda_i), .dc_i(dc_i),
		.sda_o(sda_o), .sda_oe(sda_oe), .otp_vcom(otp_vcom), .border_cfg(border_cfg), .read_red(read_red),
		.window(window), .ram_x(ram_x), .ram_y(ram_y), .analog_ctrl(analog_ctrl), .digital_ctrl(digital_ctrl),
		.update_seq(update_seq), .vcom(vcom), .busy(busy), .booster_en(booster_en), .lut_load(lut_load),
		.drive_en(drive_en));
	host_link host (.sclk(sclk), .cs_n(cs_n), .sda_i(sda_i), .dc_i(dc_i), .sda_o(sda_o), .sda_oe(sda_oe));
	// ------------------------------------------------------------
	// Clock, timeout and phase watchers
	// ------------------------------------------------------------
	initial clk = 1'b0;
	always #10 clk = ~clk;
	// Whole run needs roughly 10700 cycles; the ceiling leaves ample slack
	always @(posedge clk) begin
		cyc++;
		if (lut_load === 1'b1) saw_lut <= 1'b1;
		if (drive_en === 1'b1) saw_drive <= 1'b1;
		if (cyc == 40000) begin
			err_total++;
			give_verdict();
		end
	end
	function automatic logic [27:0] pick(input int sel);
		case (sel)
			0: return 28'(border_cfg);
			1: return 28'(read_red);
			2: return 28'(window);
			3: return 28'(ram_x);
			4: return 28'(ram_y);
			5: return 28'(analog_ctrl);
			6: return 28'(digital_ctrl);
			7: return 28'(vcom);
			8: return 28'(busy);
			9: return 28'({saw_lut, saw_drive});
			10: return 28'(update_seq);
			11: return 28'(booster_en);
			default: return 28'(host.rd_q);
		endcase
	endfunction : pick
	task check(input string nm, input logic [27:0] seen, input logic [27:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Watcher drains the notes once the driver says results have settled
	always @(got) begin
		while (notes.size() > 0) begin
			w_note = notes.pop_front();
			check(names[w_note.sel], pick(w_note.sel), w_note.val);
		end
	end
	task note(input int sel, input logic [27:0] v);
		notes.push_back('{sel, v});
	endtask : note
	// Settings land 3-4 clocks after the byte; six gives margin
	task settle(input string t);
		repeat (6) @(negedge clk);
		-> got;
		// Let the watcher drain before the driver moves on or ends the run
		@(negedge clk);
		$display("test %s done", t);
	endtask : settle
	task wait_idle;
		while (busy !== 1'b0) @(negedge clk);
	endtask : wait_idle
	task give_verdict;
		$display("checked %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{arst_n, hardware_reset_n, saw_lut, saw_drive} = 4'h0;
		otp_vcom = 8'h00;
		{err_total, samples_checked, cyc} = 0;
		void'($urandom(84));
		repeat (16) @(negedge clk);
		arst_n = 1'b1;
		repeat (2) @(negedge clk);
		hardware_reset_n = 1'b1;
		note(0, 0);
		note(1, 0);
		note(2, {epd_pkg::XS_RST, epd_pkg::XE_RST, epd_pkg::YS_RST, epd_pkg::YE_RST});
		note(3, 0);
		note(4, 9'h12b);
		settle("defaults");
		host.send(0, epd_pkg::CMD_ANALOG);
		host.send(1, 8'h54);
		host.send(0, epd_pkg::CMD_DIGITAL);
		host.send(1, 8'h3b);
		note(5, 8'h54);
		note(6, 8'h3b);
		settle("block controls");
		for (int s = 0; s < 4; s++) begin
			lv = 2'($urandom);
			tb = 2'($urandom);
			host.send(0, epd_pkg::CMD_BORDER);
			host.send(1, {s[1:0], lv, 2'b00, tb});
			note(0, {s[1:0], lv, tb});
			settle("border");
		end
		for (int v = 1; v >= 0; v--) begin
			host.send(0, epd_pkg::CMD_RD_OPT);
			host.send(1, {7'h00, v[0]});
			note(1, v[0]);
			settle("read select");
		end
		xs = 5'($urandom % 50);
		xe = 5'($urandom % 50);
		ys = 9'($urandom % 300);
		ye = 9'($urandom % 300);
		rx = 5'($urandom % 50);
		ry = 9'($urandom % 300);
		host.send(0, epd_pkg::CMD_WIN_X);
		host.send(1, {3'h0, xs});
		host.send(1, {3'h0, xe});
		host.send(0, epd_pkg::CMD_WIN_Y);
		host.send(1, ys[7:0]);
		host.send(1, {7'h00, ys[8]});
		host.send(1, ye[7:0]);
		host.send(1, {7'h00, ye[8]});
		host.send(0, epd_pkg::CMD_CNT_X);
		host.send(1, {3'h0, rx});
		host.send(0, epd_pkg::CMD_CNT_Y);
		host.send(1, ry[7:0]);
		host.send(1, {7'h00, ry[8]});
		note(2, {xs, xe, ys, ye});
		note(3, rx);
		note(4, ry);
		settle("window and counter");
		otp_vcom = 8'($urandom);
		host.send(0, epd_pkg::CMD_SW_RESET);
		note(8, 1);
		note(0, 0);
		note(2, {epd_pkg::XS_RST, epd_pkg::XE_RST, epd_pkg::YS_RST, epd_pkg::YE_RST});
		note(5, 0);
		note(7, otp_vcom);
		settle("software reset");
		wait_idle();
		host.send(0, epd_pkg::CMD_CNT_X);
		host.send(1, 8'h03);
		host.send(0, epd_pkg::CMD_WR_BW);
		host.send(1, 8'haa);
		host.send(1, 8'h55);
		note(3, 5);
		note(4, 9'h12b);
		settle("buffer write");
		host.send(0, epd_pkg::CMD_CNT_X);
		host.send(1, 8'h03);
		host.send(0, epd_pkg::CMD_WR_RED);
		host.send(1, 8'h3c);
		host.send(0, epd_pkg::CMD_RD_OPT);
		host.send(1, 8'h01);
		host.send(0, epd_pkg::CMD_CNT_X);
		host.send(1, 8'h03);
		host.send(0, epd_pkg::CMD_RD_RAM);
		host.half = 17;
		host.send(1, 8'h00);
		note(12, epd_pkg::DUMMY_BYTE);
		settle("dummy byte");
		// The first bit times of a read frame are undriven, so only the low five bits of 3Ch arrive
		host.send(1, 8'h00);
		note(12, 8'h1c);
		note(3, 5);
		settle("red read-back");
		host.send(0, epd_pkg::CMD_UPD_CTRL2);
		host.send(1, 8'hc7);
		host.send(0, epd_pkg::CMD_ACTIVATE);
		note(10, 8'hc7);
		note(8, 1);
		note(11, 1);
		settle("activation");
		wait_idle();
		note(9, 2'b11);
		note(11, 0);
		settle("update sequence");
		give_verdict();
	end
endmodule : epaper_command_sequencer_tb
